/* File: shared/fsc_map.svh */
// register offsets, field positions, reset values and timing counts of the fault/clip bank
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// register offsets on the control port
`define FSC_ADDR_FAULT      8'h08
`define FSC_ADDR_RSVD_FIRST 8'h09
`define FSC_ADDR_RSVD_LAST  8'h0f
`define FSC_ADDR_CLIP_MID   8'h10
`define FSC_ADDR_CLIP_LOW   8'h11

// fault configuration / status field positions
`define FSC_OCTH_MSB        5
`define FSC_OCTH_LSB        4
`define FSC_BIT_CLK_ERR     3
`define FSC_BIT_OC_ERR      2
`define FSC_BIT_DC_ERR      1
`define FSC_BIT_OT_ERR      0

// clip level field positions
`define FSC_CLIP_LOW_MSB    7
`define FSC_CLIP_LOW_LSB    2

// reset values
`define FSC_RST_OCTH        2'h0
`define FSC_RST_CLIP_MID    8'hff
`define FSC_RST_CLIP_LOW    8'hfc

// overcurrent threshold codes
`define FSC_OCTH_FULL       2'h0
`define FSC_OCTH_3Q         2'h1
`define FSC_OCTH_HALF       2'h2
`define FSC_OCTH_1Q         2'h3

// nominal trip level in sense units
`define FSC_OC_NOMINAL      10'h300

// timing: bit clock considered stopped after this long without an edge
`define FSC_CLK_PERIOD_NS   8
`define FSC_SCLK_STOP_NS    2000
`define FSC_SCLK_STOP_CYC   ((`FSC_SCLK_STOP_NS) / (`FSC_CLK_PERIOD_NS))

`endif

/* File: shared/fsc_pkg.sv */
// types shared by the fault/clip register bank
package fsc_pkg;

  // operating state, gray coded along shutdown -> run -> halt
  typedef enum logic [1:0] {
    FSC_ST_SHUTDOWN = 2'b00,
    FSC_ST_RUN      = 2'b01,
    FSC_ST_HALT     = 2'b11
  } fsc_dev_state_t;

  typedef logic [7:0]  fsc_byte_t;
  typedef logic [9:0]  fsc_sense_t;
  typedef logic [19:0] fsc_clip_t;

endpackage

/* File: rtl/fsc_sclk_watch.sv */
// bit clock stop watchdog for the fault/clip register bank
`include "fsc_map.svh"

module fsc_sclk_watch (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // sampled serial bit clock
  input  wire logic sclk,
  // stopped flag
  output logic      sclk_stopped
);
  import fsc_pkg::*;

  localparam int unsigned CW = 12;

  typedef struct packed {
    logic          sclk_prev; // last sample, for edge detection
    logic [CW-1:0] idle_cnt;  // cycles since the last bit clock edge
    logic          stopped;   // flag to the bank
  } fsc_watch_st_t;

  fsc_watch_st_t cur_q;
  fsc_watch_st_t nxt_d;

  ////////////////////////////////////////////////////////////////////////////////
  // next state: any edge restarts the count, saturate at the stop limit
  always_comb begin
    nxt_d           = cur_q;
    nxt_d.sclk_prev = sclk;
    if (sclk != cur_q.sclk_prev) begin
      nxt_d.idle_cnt = '0;
      nxt_d.stopped  = 1'b0;
    end else if (cur_q.idle_cnt >= CW'(`FSC_SCLK_STOP_CYC - 1)) begin
      // saturated: flag holds until the next edge
      nxt_d.stopped = 1'b1; // (R3)
    end else begin
      nxt_d.idle_cnt = cur_q.idle_cnt + CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign sclk_stopped = cur_q.stopped;

endmodule

/* File: rtl/fsc_fault_clip_regs.sv */
// fault configuration, error status and clip threshold register bank
//
// Overview of operation
// (R1) threshold code selects full, 75, 50, 25 percent
// (R2) clock error bit 3 follows fault, never latches
// (R3) stopped bit clock counts as clock error
// (R4) overcurrent latches bit 2, halts until toggle
// (R5) dc offset latches bit 1, halts until toggle
// (R6) overtemperature latches its flag, halts until toggle
// (R7) host keeps reserved bits 7:6 at zero
// (R8) host leaves addresses 0x09..0x0f alone
// (R9) clip threshold is 20 bits from three registers
// (R10) 0x10 holds threshold 13:6, resets all ones
// (R11) low register bits 7:2 carry 5:0, reset fc
// (R12) host keeps low register bits 1:0 default
// (R13) pin low or control bit enters shutdown
// (R14) status flags read only, writes ignored
// (R15) latched flags clear on shutdown release edge
`include "fsc_map.svh"

module fsc_fault_clip_regs (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // control port register access, byte wide
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output fsc_pkg::fsc_byte_t      reg_rdata,
  // shutdown sources
  input  wire logic               speaker_shutdown_n,
  input  wire logic               shutdown_ctrl_n,
  // protection detectors
  input  wire fsc_pkg::fsc_sense_t output_current,
  input  wire logic               dc_offset_detect,
  input  wire logic               over_temp_detect,
  input  wire logic               clock_fault,
  input  wire logic               sclk,
  // clip threshold assembly
  input  wire logic [5:0]         clip_level_high_bits,
  output fsc_pkg::fsc_clip_t      clip_threshold_level,
  // status to the datapath
  output logic                    normal_operation,
  output logic                    overcurrent_error,
  output logic                    dc_offset_error,
  output logic                    over_temp_error,
  output logic                    clock_error
);
  import fsc_pkg::*;

  typedef struct packed {
    fsc_dev_state_t st;        // operating state
    logic [1:0]     oc_sel;    // overcurrent threshold code
    fsc_byte_t      clip_mid;  // threshold bits 13:6
    fsc_byte_t      clip_low;  // threshold 5:0 in 7:2, reserved 1:0
    logic           oc_err;    // latched overcurrent
    logic           dc_err;    // latched dc offset
    logic           ot_err;    // latched overtemperature
    logic           clk_err;   // live clock error
    logic           sd_prev;   // shutdown seen last cycle
    fsc_byte_t      rdata;     // read data register
    fsc_clip_t      clip;      // assembled threshold
    logic           run;       // normal operation output
  } fsc_bank_st_t;

  fsc_bank_st_t cur_q;
  fsc_bank_st_t nxt_d;

  logic sclk_stopped; // from the bit clock watchdog

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // trip level for a threshold code; shifts keep it free of a divider
  function automatic fsc_sense_t oc_trip_level(input logic [1:0] code);
    fsc_sense_t nom;
    nom = `FSC_OC_NOMINAL;
    case (code)
      `FSC_OCTH_FULL: oc_trip_level = nom;                       // (R1)
      `FSC_OCTH_3Q:   oc_trip_level = nom - (nom >> 2);          // (R1)
      `FSC_OCTH_HALF: oc_trip_level = nom >> 1;                  // (R1)
      `FSC_OCTH_1Q:   oc_trip_level = nom >> 2;                  // (R1)
      default:        oc_trip_level = nom;
    endcase
  endfunction

  // true when a write targets the given register
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    wr_hit = reg_wr && (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bit clock watchdog
  fsc_sclk_watch u_sclk_watch (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sclk         (sclk),
    .sclk_stopped (sclk_stopped)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic shut_now;
    logic release_edge;
    logic oc_hit;
    logic any_latched;
    shut_now     = 1'b0;
    release_edge = 1'b0;
    oc_hit       = 1'b0;
    any_latched  = 1'b0;
    nxt_d        = cur_q;

    // either shutdown path counts; both active low
    shut_now      = !speaker_shutdown_n || !shutdown_ctrl_n; // (R13)
    nxt_d.sd_prev = shut_now;
    // only the asserted -> released transition clears, not holding shutdown
    release_edge  = cur_q.sd_prev && !shut_now; // (R15)

    // clock error is a live level, no memory
    nxt_d.clk_err = clock_fault || sclk_stopped; // (R2) (R3)

    // latched faults: clear on release, but a detection in that cycle wins
    oc_hit = output_current > oc_trip_level(cur_q.oc_sel); // (R1)
    if (release_edge) begin
      nxt_d.oc_err = 1'b0; // (R15)
      nxt_d.dc_err = 1'b0; // (R15)
      nxt_d.ot_err = 1'b0; // (R15)
    end
    if (oc_hit) begin
      nxt_d.oc_err = 1'b1; // (R4)
    end
    if (dc_offset_detect) begin
      nxt_d.dc_err = 1'b1; // (R5)
    end
    if (over_temp_detect) begin
      nxt_d.ot_err = 1'b1; // (R6)
    end
    any_latched = nxt_d.oc_err || nxt_d.dc_err || nxt_d.ot_err;

    // operating state
    case (cur_q.st)
      FSC_ST_SHUTDOWN: begin
        if (!shut_now && !any_latched) begin
          nxt_d.st = FSC_ST_RUN;
        end else if (!shut_now) begin
          nxt_d.st = FSC_ST_HALT;
        end
      end
      FSC_ST_RUN: begin
        if (shut_now) begin
          nxt_d.st = FSC_ST_SHUTDOWN;
        end else if (any_latched) begin
          nxt_d.st = FSC_ST_HALT; // (R4) (R5) (R6)
        end
      end
      FSC_ST_HALT: begin
        // only a shutdown toggle leaves halt
        if (shut_now) begin
          nxt_d.st = FSC_ST_SHUTDOWN; // (R4) (R5) (R6)
        end
      end
      default: begin
        nxt_d.st = FSC_ST_SHUTDOWN;
      end
    endcase
    // clock error only pauses output; state is kept so recovery is automatic
    nxt_d.run = (nxt_d.st == FSC_ST_RUN) && !nxt_d.clk_err; // (R2)

    // register writes; status bits and reserved 7:6 are not stored
    if (wr_hit(reg_addr, `FSC_ADDR_FAULT)) begin
      nxt_d.oc_sel = reg_wdata[`FSC_OCTH_MSB:`FSC_OCTH_LSB]; // (R14)
    end
    if (wr_hit(reg_addr, `FSC_ADDR_CLIP_MID)) begin
      nxt_d.clip_mid = reg_wdata; // (R10)
    end
    if (wr_hit(reg_addr, `FSC_ADDR_CLIP_LOW)) begin
      nxt_d.clip_low = reg_wdata; // (R11)
    end

    // threshold assembled from the registered mid and low segments and the live clip_level_high_bits input
    nxt_d.clip = {clip_level_high_bits, cur_q.clip_mid,
                  cur_q.clip_low[`FSC_CLIP_LOW_MSB:`FSC_CLIP_LOW_LSB]}; // (R9)

    // reads: answer one cycle later, unmapped and reserved read zero
    if (reg_rd) begin
      case (reg_addr)
        `FSC_ADDR_FAULT: begin
          nxt_d.rdata = {2'h0, cur_q.oc_sel, cur_q.clk_err,
                         cur_q.oc_err, cur_q.dc_err, cur_q.ot_err};
        end
        `FSC_ADDR_CLIP_MID: begin
          nxt_d.rdata = cur_q.clip_mid;
        end
        `FSC_ADDR_CLIP_LOW: begin
          nxt_d.rdata = cur_q.clip_low;
        end
        default: begin
          nxt_d.rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_q          <= '0;
      cur_q.st       <= FSC_ST_SHUTDOWN;
      cur_q.oc_sel   <= `FSC_RST_OCTH;
      cur_q.clip_mid <= `FSC_RST_CLIP_MID; // (R10)
      cur_q.clip_low <= `FSC_RST_CLIP_LOW; // (R11)
      cur_q.sd_prev  <= 1'b1;
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign reg_rdata            = cur_q.rdata;
  assign clip_threshold_level = cur_q.clip;
  assign normal_operation     = cur_q.run;
  assign overcurrent_error    = cur_q.oc_err;
  assign dc_offset_error      = cur_q.dc_err;
  assign over_temp_error      = cur_q.ot_err;
  assign clock_error          = cur_q.clk_err;

endmodule

/* File: testbench/fsc_regs_checker.sv */
// assertions on the fault/clip register bank ports
`include "fsc_map.svh"
module fsc_regs_checker (
  // clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // register port
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  // shutdown sources and detectors
  input wire logic               speaker_shutdown_n,
  input wire logic               shutdown_ctrl_n,
  input wire logic               dc_offset_detect,
  input wire logic               over_temp_detect,
  input wire logic               clock_fault,
  // outputs watched
  input wire logic [5:0]         clip_level_high_bits,
  input wire fsc_pkg::fsc_clip_t clip_threshold_level,
  input wire logic               normal_operation,
  input wire logic               overcurrent_error,
  input wire logic               dc_offset_error,
  input wire logic               over_temp_error,
  input wire logic               clock_error
);
  import fsc_pkg::*;
  logic sd;   // shutdown asked by either source
  logic sd_q; // shutdown one cycle ago
  logic rel;  // release edge this cycle
  assign sd = !speaker_shutdown_n || !shutdown_ctrl_n;
  assign rel = sd_q && !sd;
  // resets to shutdown, as the block treats a release after reset as an edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sd_q <= 1'b1;
    end else begin
      sd_q <= sd;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // write strobe, then two cycles until the threshold shows it
  sequence mid_wr_s;
    reg_wr && reg_addr == `FSC_ADDR_CLIP_MID ##2 1'b1;
  endsequence
  sequence low_wr_s;
    reg_wr && reg_addr == `FSC_ADDR_CLIP_LOW ##2 1'b1;
  endsequence
  dc_latch_a: assert property (dc_offset_detect |=> dc_offset_error && !normal_operation)
    else $error("dc offset flag not raised");
  ot_latch_a: assert property (over_temp_detect |=> over_temp_error && !normal_operation)
    else $error("overtemperature flag not raised");
  clk_err_a: assert property (clock_fault |=> clock_error && !normal_operation)
    else $error("clock error not shown");
  oc_hold_a: assert property (overcurrent_error && !rel |=> overcurrent_error)
    else $error("overcurrent flag dropped without release");
  dc_clear_a: assert property (dc_offset_error && rel && !dc_offset_detect |=> !dc_offset_error)
    else $error("dc flag kept after release");
  halt_a: assert property (overcurrent_error || dc_offset_error || over_temp_error |-> !normal_operation)
    else $error("running with a latched fault");
  flag_ro_a: assert property (reg_wr && reg_addr == `FSC_ADDR_FAULT && !dc_offset_detect
    && !dc_offset_error |=> !dc_offset_error)
    else $error("status flag written by host");
  clip_mid_a: assert property (mid_wr_s |-> clip_threshold_level[13:6] == $past(reg_wdata, 2))
    else $error("middle clip bits wrong");
  clip_low_a: assert property (low_wr_s |-> clip_threshold_level[5:0] == $past(reg_wdata[7:2], 2))
    else $error("low clip bits wrong");
  clip_hi_a: assert property (1'b1 |=> clip_threshold_level[19:14] == $past(clip_level_high_bits))
    else $error("high clip bits wrong");
endmodule
bind fsc_fault_clip_regs fsc_regs_checker chk (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .speaker_shutdown_n, .shutdown_ctrl_n, .dc_offset_detect, .over_temp_detect, .clock_fault,
  .clip_level_high_bits, .clip_threshold_level, .normal_operation, .overcurrent_error,
  .dc_offset_error, .over_temp_error, .clock_error);

/* File: testbench/fsc_host_model.sv */
// host model: control port accesses and the shutdown control bit
module fsc_host_model (
  // clock
  input  wire logic               mclk,
  // register port
  output logic [7:0]              reg_addr,
  output logic [7:0]              reg_wdata,
  output logic                    reg_wr,
  output logic                    reg_rd,
  input  wire fsc_pkg::fsc_byte_t reg_rdata,
  // shutdown control bit, active low
  output logic                    shutdown_ctrl_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    shutdown_ctrl_n = 1'b1;
  end
  // one strobe cycle; released lines show inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  // data is held until the next read, so one extra cycle is safe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge mclk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // shutdown bit path, an alternative to the pin
  task automatic sd(input logic v);
    @(negedge mclk);
    shutdown_ctrl_n = v;
  endtask
endmodule

/* File: testbench/test_fault_status_and_clip_level_regs.sv */
// self-checking bench for the fault/clip register bank
`include "fsc_map.svh"
module test_fault_status_and_clip_level_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, sclk, sclk_run, speaker_shutdown_n, reg_wr, reg_rd, shutdown_ctrl_n;
  logic dc_offset_detect, over_temp_detect, clock_fault, normal_operation, clock_error;
  logic overcurrent_error, dc_offset_error, over_temp_error;
  logic [7:0] reg_addr, reg_wdata, rv;
  logic [5:0] clip_level_high_bits;
  fsc_pkg::fsc_byte_t reg_rdata;
  fsc_pkg::fsc_clip_t clip_threshold_level;
  fsc_pkg::fsc_sense_t output_current;
  fsc_pkg::fsc_sense_t lvl [4]; // trip level per threshold code
  int mismatches = 0;
  int comparisons = 0;
  fsc_host_model host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shutdown_ctrl_n);
  fsc_fault_clip_regs dut (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .speaker_shutdown_n   (speaker_shutdown_n),
    .shutdown_ctrl_n      (shutdown_ctrl_n),
    .output_current       (output_current),
    .dc_offset_detect     (dc_offset_detect),
    .over_temp_detect     (over_temp_detect),
    .clock_fault          (clock_fault),
    .sclk                 (sclk),
    .clip_level_high_bits (clip_level_high_bits),
    .clip_threshold_level (clip_threshold_level),
    .normal_operation     (normal_operation),
    .overcurrent_error    (overcurrent_error),
    .dc_offset_error      (dc_offset_error),
    .over_temp_error      (over_temp_error),
    .clock_error          (clock_error)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // bit clock runs off the falling edge unless a test stops it
  always @(negedge mclk) begin
    if (sclk_run) begin
      sclk <= ~sclk;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(rv, e);
  endtask
  // pin held low two cycles, then released
  task automatic pin_toggle();
    @(negedge mclk);
    speaker_shutdown_n = 1'b0;
    cyc(2);
    speaker_shutdown_n = 1'b1;
    cyc(2);
  endtask
  // hang guard for the whole run
  initial begin
    repeat (50000) @(posedge mclk);
    mismatches++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, speaker_shutdown_n, sclk, sclk_run} = 4'b1101;
    {dc_offset_detect, over_temp_detect, clock_fault} = '0;
    output_current = '0;
    clip_level_high_bits = 6'h2d;
    lvl = '{`FSC_OC_NOMINAL, `FSC_OC_NOMINAL * 3 / 4, `FSC_OC_NOMINAL / 2, `FSC_OC_NOMINAL / 4};
    cyc(8);
    sys_rst = 1'b0;
    cyc(1);
    chk(clip_threshold_level, {6'h2d, 8'hff, 6'h3f});
    rdchk(`FSC_ADDR_FAULT, 8'h00);
    rdchk(`FSC_ADDR_CLIP_LOW, 8'hfc);
    // rows: each code, at its level and one above
    for (int k = 0; k < 4; k++) begin
      host.wr(`FSC_ADDR_FAULT, {2'b00, k[1:0], 4'h0});
      rdchk(`FSC_ADDR_FAULT, {2'b00, k[1:0], 4'h0});
      output_current = lvl[k];
      cyc(2);
      chk(overcurrent_error, 1'b0);
      output_current = lvl[k] + 1'b1;
      cyc(2);
      chk({overcurrent_error, normal_operation}, 2'b10);
      output_current = '0;
      cyc(3);
      chk(overcurrent_error, 1'b1);
      pin_toggle();
      chk({overcurrent_error, normal_operation}, 2'b01);
    end
    // one-cycle dc fault, cleared through the control bit
    dc_offset_detect = 1'b1;
    cyc(1);
    dc_offset_detect = 1'b0;
    cyc(1);
    chk({dc_offset_error, normal_operation}, 2'b10);
    host.wr(`FSC_ADDR_FAULT, 8'h0f);
    rdchk(`FSC_ADDR_FAULT, 8'h02);
    host.sd(1'b0);
    cyc(4);
    chk(dc_offset_error, 1'b1);
    host.sd(1'b1);
    cyc(2);
    chk({dc_offset_error, normal_operation}, 2'b01);
    over_temp_detect = 1'b1;
    cyc(1);
    over_temp_detect = 1'b0;
    rdchk(`FSC_ADDR_FAULT, 8'h01);
    pin_toggle();
    chk({over_temp_error, normal_operation}, 2'b01);
    // detection in the release cycle: the set wins and the bank halts
    speaker_shutdown_n = 1'b0;
    cyc(2);
    chk(normal_operation, 1'b0);
    speaker_shutdown_n = 1'b1;
    dc_offset_detect = 1'b1;
    cyc(1);
    dc_offset_detect = 1'b0;
    cyc(1);
    chk({dc_offset_error, normal_operation}, 2'b10);
    pin_toggle();
    chk({dc_offset_error, normal_operation}, 2'b01);
    clock_fault = 1'b1;
    cyc(2);
    rdchk(`FSC_ADDR_FAULT, 8'h08);
    clock_fault = 1'b0;
    cyc(2);
    chk({clock_error, normal_operation}, 2'b01);
    // stopped bit clock must be flagged near 250 cycles, not sooner
    sclk_run = 1'b0;
    cyc(240);
    chk(clock_error, 1'b0);
    for (int i = 0; i < 30 && clock_error !== 1'b1; i++) cyc(1);
    chk({clock_error, normal_operation}, 2'b10);
    sclk_run = 1'b1;
    cyc(4);
    chk({clock_error, normal_operation}, 2'b01);
    clip_level_high_bits = 6'h15;
    host.wr(`FSC_ADDR_CLIP_MID, 8'h12);
    host.wr(`FSC_ADDR_CLIP_LOW, 8'ha4);
    cyc(2);
    chk(clip_threshold_level, {6'h15, 8'h12, 6'h29});
    rdchk(`FSC_ADDR_CLIP_LOW, 8'ha4);
    // unmapped space past the bank: writes dropped, reads zero
    // the reserved range 0x09..0x0f is never touched by the host
    for (int a = 'h12; a < 'h19; a++) begin
      host.wr(a[7:0], 8'h5a);
      rdchk(a[7:0], 8'h00);
    end
    rdchk(`FSC_ADDR_CLIP_MID, 8'h12);
    // second reset mid-run
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    rdchk(`FSC_ADDR_CLIP_MID, 8'hff);
    close_out();
  end
endmodule
